//--- cias_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants, types and helpers for the cooling injection
//          actuation sequencer
// Assumes: 20 MHz system clock, 1 ms prescaled timing tick
// Notes:   long counts are defaults for top-level parameters
//////////////////////////////////////////////////////////////////////////////
package cias_pkg;

   // clock and tick timing
   localparam int unsigned CLK_MHZ = 20;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int unsigned TICKS_PER_S = 1_000_000 / TICK_US;

   // persistence times as printed
   localparam int unsigned L1_PERSIST_S = 10;
   localparam int unsigned DWP_PERSIST_MIN = 60;
   localparam int unsigned L1_PERSIST_TICKS = L1_PERSIST_S * TICKS_PER_S;
   localparam int unsigned DWP_PERSIST_TICKS = DWP_PERSIST_MIN * 60 * TICKS_PER_S;

   // time delays after initiation, in ticks (values not given, plain defaults)
   localparam int unsigned INJ_DELAY_TICKS = 5000;
   localparam int unsigned EQ_DELAY_TICKS = 10000;

   // valve and division counts, manual and trip vote thresholds
   localparam int unsigned N_INJ = 8;
   localparam int unsigned N_EQ = 4;
   localparam int unsigned N_DIV = 4;
   localparam logic [2:0] MAN_VOTE_MIN = 3'h2;
   localparam logic [2:0] TRIP_VOTE_MIN = 3'h2;

   // register indices on the plain port (word address)
   localparam logic [7:0] REG_VALVE_ARM = 8'h00;
   localparam logic [7:0] REG_VALVE_FIRE = 8'h01;
   localparam logic [7:0] REG_STATUS = 8'h02;
   localparam logic [7:0] REG_VALVE_OUT = 8'h03;

   // field layout of the valve arm/fire words
   localparam int unsigned FLD_INJ_LSB = 0;
   localparam int unsigned FLD_EQ_LSB = 8;

   // status word bit positions
   localparam int unsigned ST_AUTO_SEAL = 0;
   localparam int unsigned ST_MAN_SEAL = 1;
   localparam int unsigned ST_SEQ_LSB = 2;
   localparam int unsigned ST_EQ_DONE = 4;
   localparam int unsigned ST_DIV_OP_LSB = 8;
   localparam int unsigned ST_VOTE_LSB = 12;

   // sequencer states
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_DONE} cias_seq_t;

   // divisional trip inputs, one bit per division
   typedef struct packed {
      logic [3:0] l1;
      logic [3:0] l05;
      logic [3:0] dwp;
   } cias_trips_t;

   // squib firing commands
   typedef struct packed {
      logic [7:0] inj;
      logic [3:0] eq;
   } cias_fire_t;

   // number of set bits in a four-bit group
   function automatic logic [2:0] cias_ones4(input logic [3:0] v);
      cias_ones4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
   endfunction

endpackage

//--- cias_vote.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-out-of-four divisional trip vote with division bypass
// Assumes: inputs synchronous to clk
// Notes:   two or more bypass flags are treated as no bypass
//////////////////////////////////////////////////////////////////////////////
module cias_vote
   import cias_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // divisional trips and bypass
   input wire logic [3:0] trip,
   input wire logic [3:0] bypass,
   // voted decision
   output logic voted
);

   logic [3:0] eff;
   logic one_byp;

   // a single bypass drops that division, leaving two of three
   always_comb
   begin
      one_byp = (cias_ones4(bypass) == 3'h1);
      eff = one_byp ? (trip & ~bypass) : trip;
      voted = (cias_ones4(eff) >= TRIP_VOTE_MIN);
   end

   // two live trips always win, whatever the bypass state
   property p_vote_two;
      @(posedge clk) disable iff (!rst_n)
         (cias_ones4(trip & ~bypass) >= TRIP_VOTE_MIN) |-> voted;
   endproperty
   a_vote_two: assert property (p_vote_two) else $error("vote missed two trips"); // [RULE18]

endmodule // cias_vote

//--- cias_persist.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: persistence timer for one voted trip
// Assumes: tick is a one-cycle pulse from the prescaler
// Notes:   any drop of the trip restarts the count from zero
//////////////////////////////////////////////////////////////////////////////
module cias_persist
   import cias_pkg::*;
#(
   parameter logic [31:0] LIMIT = 32'h0000_000a
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // timing
   input wire logic tick,
   input wire logic trip,
   // trip held for the full time
   output logic done
);

   typedef struct packed {
      logic [31:0] cnt;
   } cias_pst_t;

   cias_pst_t st_reg;
   cias_pst_t st_next;

   // count ticks while tripped, saturate at the limit
   always_comb
   begin
      st_next = st_reg;
      if (!trip)
         st_next.cnt = 32'h0000_0000; // [RULE16]
      else if (tick && st_reg.cnt < LIMIT)
         st_next.cnt = st_reg.cnt + 32'h0000_0001; // [RULE21]
      done = trip && (st_reg.cnt == LIMIT);
   end

   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   property p_restart;
      @(posedge clk) disable iff (!rst_n)
         !trip |=> (st_reg.cnt == 32'h0000_0000) && !done;
   endproperty
   a_restart: assert property (p_restart) else $error("timer not cleared"); // [RULE16]

endmodule // cias_persist

//--- cias_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: actuation sequencer for gravity cooling injection and equalizing
// Assumes: all inputs synchronous to clk; trips come per division
// Notes:   firing outputs are sticky until reset; squibs fire only once
//
// Overview of operation
// RULE1: start injection delay after voted Level 1 trip held 10 seconds.
// RULE2: also start the delay after drywell pressure high held 60 minutes.
// RULE3: when injection delay expires, open all eight injection valves together.
// RULE4: fire four equalizing valves after Level 1 plus delay and Level 0.5 trip; the code starts that delay on any seal-in, automatic or manual.
// RULE5: failed-scram condition blocks automatic injection and equalizing initiation.
// RULE6: any two of four divisional manual arm/fire operations seal in sequencing.
// RULE7: system manual initiation has no effect without the pressure interlock.
// RULE8: operator gives arm and fire on each of two divisional switches.
// RULE9: any arm action on any manual path raises a plant alarm.
// RULE10: each injection valve opens alone by arm then fire, low pressure only.
// RULE11: each equalizing valve opens alone by arm then fire, low pressure only.
// RULE12: backup protection platform keeps its own per-valve arm/fire path.
// RULE13: pool level high and pool level low each raise an alarm.
// RULE14: no single fault in logic or inputs may fire a squib alone.
// RULE15: manual initiation is honoured at any time with interlocks satisfied.
// RULE16: a trip dropping before its persistence time restarts its timer.
// RULE17: once sealed in, the sequence cannot be aborted by the operator.
// RULE18: each trip decision is a two-out-of-four divisional vote.
// RULE19: one bypassed division reduces the vote to two-out-of-three.
// RULE20: injection and equalizing delays are configurable constants.
// RULE21: times count on a prescaled tick; reset clears timers and seal-in.
//////////////////////////////////////////////////////////////////////////////
//
// The placing of the registers and strobed register access are this design's own decisions.
module cias_top
   import cias_pkg::*;
#(
   parameter logic [31:0] TICK_LEN = TICK_CYCLES,
   parameter logic [31:0] L1_TICKS = L1_PERSIST_TICKS,
   parameter logic [31:0] DWP_TICKS = DWP_PERSIST_TICKS,
   parameter logic [31:0] INJ_TICKS = INJ_DELAY_TICKS,
   parameter logic [31:0] EQ_TICKS = EQ_DELAY_TICKS
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // divisional trips and bypass
   input wire cias_trips_t trips,
   input wire logic [3:0] div_bypass,
   // plant conditions
   input wire logic failed_scram_condition,
   input wire logic low_pressure,
   input wire logic pool_level_high,
   input wire logic pool_level_low,
   // divisional manual switches from the operator display
   input wire logic [3:0] man_arm,
   input wire logic [3:0] man_fire,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // squib firing commands and alarms
   output cias_fire_t fire,
   output logic alarm_arm,
   output logic alarm_pool_high,
   output logic alarm_pool_low
);

   typedef struct packed {
      logic [31:0] pre;
      cias_seq_t seq;
      logic auto_seal;
      logic man_seal;
      logic [31:0] dly_a;
      logic [31:0] dly_b;
      logic [31:0] eq_dly;
      logic [3:0] div_arm;
      logic [3:0] div_op;
      logic [11:0] v_arm;
      cias_fire_t fire;
      logic alarm_arm;
      logic pool_hi;
      logic pool_lo;
      logic [31:0] rdata;
   } cias_st_t;

   cias_st_t st_reg;
   cias_st_t st_next;

   logic tick;
   logic v_l1;
   logic v_l05;
   logic v_dwp;
   logic l1_done;
   logic dwp_done;
   logic sealed;
   logic eq_done;
   logic [11:0] vfire;

   //////////////////////////////////////////////////////////////////////////
   // divisional votes
   //////////////////////////////////////////////////////////////////////////

   // level 1 vote
   cias_vote u_vote_l1 (
      .clk(clk),
      .rst_n(rst_n),
      .trip(trips.l1),
      .bypass(div_bypass),
      .voted(v_l1)
   ); // [RULE18] [RULE19]

   // level 0.5 vote
   cias_vote u_vote_l05 (
      .clk(clk),
      .rst_n(rst_n),
      .trip(trips.l05),
      .bypass(div_bypass),
      .voted(v_l05)
   ); // [RULE18] [RULE19]

   // drywell pressure vote
   cias_vote u_vote_dwp (
      .clk(clk),
      .rst_n(rst_n),
      .trip(trips.dwp),
      .bypass(div_bypass),
      .voted(v_dwp)
   ); // [RULE18] [RULE19]

   //////////////////////////////////////////////////////////////////////////
   // persistence timers
   //////////////////////////////////////////////////////////////////////////

   // level 1 must hold ten seconds
   cias_persist #(.LIMIT(L1_TICKS)) u_pers_l1 (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .trip(v_l1),
      .done(l1_done)
   ); // [RULE1]

   // drywell pressure must hold sixty minutes
   cias_persist #(.LIMIT(DWP_TICKS)) u_pers_dwp (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .trip(v_dwp),
      .done(dwp_done)
   ); // [RULE2]

   //////////////////////////////////////////////////////////////////////////
   // sequencing
   //////////////////////////////////////////////////////////////////////////

   // decoded helpers from current state
   assign tick = (st_reg.pre == TICK_LEN - 32'h0000_0001);
   assign sealed = st_reg.auto_seal || st_reg.man_seal;
   assign eq_done = (st_reg.eq_dly == EQ_TICKS);
   assign vfire = wdata[11:0] & st_reg.v_arm;

   // next-state logic for the whole block
   always_comb
   begin
      st_next = st_reg;

      // tick prescaler
      if (tick)
         st_next.pre = 32'h0000_0000; // [RULE21]
      else
         st_next.pre = st_reg.pre + 32'h0000_0001;

      // automatic seal-in, blocked under failed scram, never released
      if ((l1_done || dwp_done) && !failed_scram_condition)
         st_next.auto_seal = 1'b1; // [RULE1] [RULE2] [RULE5] [RULE17]

      // divisional manual switches: fire counts only after its arm
      st_next.div_arm = st_reg.div_arm | man_arm;
      st_next.div_op = st_reg.div_op | (man_fire & st_reg.div_arm); // [RULE6]

      // two operated divisions seal in, gated by pressure interlock
      if (cias_ones4(st_reg.div_op) >= MAN_VOTE_MIN && low_pressure)
         st_next.man_seal = 1'b1; // [RULE6] [RULE7] [RULE15]

      // redundant delay lanes must both expire so one upset cannot fire
      unique case (st_reg.seq)
         SEQ_IDLE:
         begin
            st_next.dly_a = 32'h0000_0000;
            st_next.dly_b = 32'h0000_0000;
            if (sealed)
               st_next.seq = SEQ_DELAY;
         end
         SEQ_DELAY:
         begin
            if (tick && st_reg.dly_a < INJ_TICKS)
               st_next.dly_a = st_reg.dly_a + 32'h0000_0001; // [RULE20]
            if (tick && st_reg.dly_b < INJ_TICKS)
               st_next.dly_b = st_reg.dly_b + 32'h0000_0001;
            if (st_reg.dly_a == INJ_TICKS && st_reg.dly_b == INJ_TICKS)
               st_next.seq = SEQ_DONE; // [RULE14]
         end
         SEQ_DONE:
         begin
            st_next.fire.inj = '1; // [RULE3]
         end
      endcase

      // equalizing permissive delay runs once sealed
      if (sealed && tick && st_reg.eq_dly < EQ_TICKS)
         st_next.eq_dly = st_reg.eq_dly + 32'h0000_0001; // [RULE20]

      // equalizing needs the delay and level 0.5; failed scram stops auto path
      if (eq_done && v_l05 && (st_reg.man_seal || !failed_scram_condition))
         st_next.fire.eq = '1; // [RULE4] [RULE5]

      // per-valve arm and fire over the register port
      if (wr && addr == REG_VALVE_ARM)
         st_next.v_arm = wdata[11:0];
      if (wr && addr == REG_VALVE_FIRE && low_pressure)
      begin
         st_next.fire.inj = st_next.fire.inj | vfire[FLD_INJ_LSB +: N_INJ]; // [RULE10]
         st_next.fire.eq = st_next.fire.eq | vfire[FLD_EQ_LSB +: N_EQ]; // [RULE11]
      end

      // alarms
      st_next.alarm_arm = (|man_arm) || (|st_next.v_arm); // [RULE9]
      st_next.pool_hi = pool_level_high; // [RULE13]
      st_next.pool_lo = pool_level_low; // [RULE13]

      // read data stands only in the cycle after the strobe
      st_next.rdata = 32'h0000_0000;
      if (rd)
      begin
         unique case (addr)
            REG_VALVE_ARM:
               st_next.rdata = {20'h0_0000, st_reg.v_arm};
            REG_STATUS:
            begin
               st_next.rdata[ST_AUTO_SEAL] = st_reg.auto_seal;
               st_next.rdata[ST_MAN_SEAL] = st_reg.man_seal;
               st_next.rdata[ST_SEQ_LSB +: 2] = st_reg.seq;
               st_next.rdata[ST_EQ_DONE] = eq_done;
               st_next.rdata[ST_DIV_OP_LSB +: N_DIV] = st_reg.div_op;
               st_next.rdata[ST_VOTE_LSB +: 3] = {v_dwp, v_l05, v_l1};
            end
            REG_VALVE_OUT:
               st_next.rdata = {20'h0_0000, st_reg.fire.inj, st_reg.fire.eq};
            default:
               st_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // one register for all state; reset clears timers and seal-in
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0; // [RULE21]
      else
         st_reg <= st_next;
   end

   // outputs straight from flops
   assign rdata = st_reg.rdata;
   assign fire = st_reg.fire;
   assign alarm_arm = st_reg.alarm_arm;
   assign alarm_pool_high = st_reg.pool_hi;
   assign alarm_pool_low = st_reg.pool_lo;

   //////////////////////////////////////////////////////////////////////////
   // checks
   //////////////////////////////////////////////////////////////////////////

   property p_inj_all;
      @(posedge clk) disable iff (!rst_n)
         (st_reg.seq == SEQ_DONE) |=> (fire.inj == 8'hff);
   endproperty
   a_inj_all: assert property (p_inj_all) else $error("not all valves open"); // [RULE3]

   property p_delay_first;
      @(posedge clk) disable iff (!rst_n)
         (st_reg.seq != SEQ_DONE &&
            (st_reg.dly_a != INJ_TICKS || st_reg.dly_b != INJ_TICKS)) |=>
            (st_reg.seq != SEQ_DONE);
   endproperty
   a_delay_first: assert property (p_delay_first) else $error("delay skipped"); // [RULE14]

   property p_inhibit;
      @(posedge clk) disable iff (!rst_n)
         (failed_scram_condition && !st_reg.auto_seal) |=> !st_reg.auto_seal;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("auto seal under inhibit"); // [RULE5]

   property p_seal_hold;
      @(posedge clk) disable iff (!rst_n)
         sealed |=> sealed [*8];
   endproperty
   a_seal_hold: assert property (p_seal_hold) else $error("seal released"); // [RULE17]

   property p_man_interlock;
      @(posedge clk) disable iff (!rst_n)
         (!low_pressure && !st_reg.man_seal) |=> !st_reg.man_seal;
   endproperty
   a_man_interlock: assert property (p_man_interlock) else $error("manual w/o interlock"); // [RULE7]

   property p_man_two;
      @(posedge clk) disable iff (!rst_n)
         (cias_ones4(st_reg.div_op) >= MAN_VOTE_MIN && low_pressure) |=> st_reg.man_seal;
   endproperty
   a_man_two: assert property (p_man_two) else $error("manual vote ignored"); // [RULE6]

   property p_eq_gate;
      @(posedge clk) disable iff (!rst_n)
         ((!eq_done || !v_l05) && !wr) |=> $stable(fire.eq);
   endproperty
   a_eq_gate: assert property (p_eq_gate) else $error("equalize without cause"); // [RULE4]

   property p_arm_alarm;
      @(posedge clk) disable iff (!rst_n)
         (|man_arm) |=> alarm_arm;
   endproperty
   a_arm_alarm: assert property (p_arm_alarm) else $error("arm alarm missing"); // [RULE9]

   property p_valve_lowp;
      @(posedge clk) disable iff (!rst_n)
         (!low_pressure && st_reg.seq != SEQ_DONE && !v_l05) |=> $stable(fire);
   endproperty
   a_valve_lowp: assert property (p_valve_lowp) else $error("valve fired at pressure"); // [RULE10]

   property p_pool;
      @(posedge clk) disable iff (!rst_n)
         (pool_level_high ##0 pool_level_low) |=> (alarm_pool_high && alarm_pool_low);
   endproperty
   a_pool: assert property (p_pool) else $error("pool alarm missing"); // [RULE13]

endmodule // cias_top

//--- cias_field.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: far side model: divisional trip voters and operator display switches
// Assumes: requests change just after a rising edge of clk
// Notes:   arm shows two cycles before fire, never both together
//////////////////////////////////////////////////////////////////////////////
module cias_field
   import cias_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // requests from the bench
   input wire cias_trips_t seen,
   input wire logic [3:0] op_mask,
   input wire logic op_go,
   // towards the sequencer
   output cias_trips_t trips,
   output logic [3:0] man_arm,
   output logic [3:0] man_fire
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] mask_reg;
   logic [2:0] step_reg;

   //////////////////////////////////////////////////////////////////////////
   // trips relayed one cycle late, as over a voter link
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trips <= '0;
         mask_reg <= 4'h0;
         step_reg <= 3'h0;
      end
      else
      begin
         trips <= seen;
         if (op_go)
         begin
            mask_reg <= op_mask;
            step_reg <= 3'h1;
         end
         else if (step_reg != 3'h0)
            step_reg <= step_reg + 3'h1;
      end
   end

   // backup platform keeps its own per-valve arm/fire, never routed through here
   // two separate deliberate actions per switch: arm, then fire
   assign man_arm = (step_reg inside {3'h1, 3'h2}) ? mask_reg : 4'h0;
   assign man_fire = (step_reg inside {3'h3, 3'h4}) ? mask_reg : 4'h0;
endmodule // cias_field

//--- cooling_injection_actuation_sequencer_bench.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the actuation sequencer
// Assumes: shortened tick and delay counts so the run stays short
// Notes:   timing bounds allow for the unknown phase of the tick
//////////////////////////////////////////////////////////////////////////////
`define CHK(n, e, g) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         err_total++; \
         $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
      end \
   end

module cooling_injection_actuation_sequencer_bench
   import cias_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TL = 4;
   localparam int PL1 = 5;
   localparam int PDW = 8;
   localparam int PINJ = 3;
   localparam int PEQ = 6;
   typedef struct {string n; logic [31:0] e; logic [31:0] m;} cias_note_t;
   cias_note_t notes[$];
   cias_note_t cur;
   cias_trips_t seen;
   cias_trips_t trips;
   cias_fire_t fire;
   logic clk, rst_n, wr, rd, rd_d, op_go, failed_scram_condition, low_pressure;
   logic pool_level_high, pool_level_low, alarm_arm, alarm_pool_high, alarm_pool_low;
   logic [3:0] div_bypass, man_arm, man_fire, op_mask, bp;
   logic [7:0] addr;
   logic [11:0] fv, tv;
   logic [31:0] wdata, rdata, a, f;
   int err_total, check_count, cyc;

   assign fv = fire;

   //////////////////////////////////////////////////////////////////////////
   // design and far side
   cias_top #(.TICK_LEN(32'(TL)), .L1_TICKS(32'(PL1)), .DWP_TICKS(32'(PDW)),
      .INJ_TICKS(32'(PINJ)), .EQ_TICKS(32'(PEQ))) dut (
      .clk(clk), .rst_n(rst_n), .trips(trips), .div_bypass(div_bypass),
      .failed_scram_condition(failed_scram_condition), .low_pressure(low_pressure),
      .pool_level_high(pool_level_high), .pool_level_low(pool_level_low),
      .man_arm(man_arm), .man_fire(man_fire), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .fire(fire), .alarm_arm(alarm_arm),
      .alarm_pool_high(alarm_pool_high), .alarm_pool_low(alarm_pool_low));
   cias_field field (.clk(clk), .rst_n(rst_n), .seen(seen), .op_mask(op_mask),
      .op_go(op_go), .trips(trips), .man_arm(man_arm), .man_fire(man_fire));

   //////////////////////////////////////////////////////////////////////////
   // clock, and a ceiling on the run
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         results();
      end
   end

   // read answers stand only in the cycle after the strobe
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk)
   begin
      if (rd_d === 1'b1 && notes.size() > 0)
      begin
         cur = notes.pop_front();
         `CHK(cur.n, cur.e & cur.m, rdata & cur.m)
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // own reference vote, kept apart from the design's helpers
   function automatic logic vote(input logic [3:0] t, input logic [3:0] b);
      int c;
      c = ($countones(b) == 1) ? $countones(t & ~b) : $countones(t);
      return 1'(c >= 2);
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      seen <= '0;
      div_bypass <= 4'h0;
      failed_scram_condition <= 1'b0;
      low_pressure <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic set_trips(input logic [11:0] v);
      @(posedge clk);
      seen <= v;
   endtask

   task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input string nm, input logic [7:0] ad, input logic [31:0] e,
      input logic [31:0] m);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      notes.push_back(cias_note_t'{nm, e, m});
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // operator works the arm/fire switches of the given divisions
   task automatic op(input logic [3:0] m);
      @(posedge clk);
      op_mask <= m;
      op_go <= 1'b1;
      @(posedge clk);
      op_go <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      `CHK("arm alarm", 1'b1, alarm_arm)
      repeat (6) @(posedge clk);
   endtask

   // polls on the falling edge so fire is settled when looked at
   task automatic wait_fire(input string nm, input int lo, input int hi,
      input logic [11:0] sel, input logic [11:0] ev);
      int k;
      k = 0;
      while ((fv & sel) === 12'h000 && k < hi)
      begin
         @(negedge clk);
         k++;
      end
      `CHK(nm, ev, fv & sel)
      `CHK(nm, 1'b1, k >= lo)
   endtask

   //////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {rst_n, wr, rd, op_go, failed_scram_condition, low_pressure} = 6'h00;
      {pool_level_high, pool_level_low} = 2'h0;
      {seen, div_bypass, op_mask, addr, wdata} = '0;
      void'($urandom(32'h63e2));
      do_reset();
      rd_reg("status", REG_STATUS, 32'h0000_0000, 32'hffff_ffff);
      rd_reg("valve out", REG_VALVE_OUT, 32'h0000_0000, 32'hffff_ffff);
      wr_reg(8'h7f, 32'hffff_ffff);
      rd_reg("unmapped", 8'h7f, 32'h0000_0000, 32'hffff_ffff);
      // random divisional trips and bypass, dropped before any persistence ends
      repeat (24)
      begin
         tv = 12'($urandom);
         bp = 4'($urandom);
         @(posedge clk);
         seen <= tv;
         div_bypass <= bp;
         repeat (3) @(posedge clk);
         rd_reg("votes", REG_STATUS, {17'h0, vote(tv[3:0], bp), vote(tv[7:4], bp),
            vote(tv[11:8], bp), 12'h0}, 32'h0000_7000);
         set_trips(12'h000);
         div_bypass <= 4'h0;
         repeat (2) @(posedge clk);
      end
      // one division alone can never fire
      set_trips(12'h111);
      repeat (100) @(negedge clk);
      `CHK("single division", 12'h000, fv)
      // level 1 interrupted, then sustained
      set_trips(12'h300);
      repeat (16) @(posedge clk);
      set_trips(12'h000);
      rd_reg("interrupted trip", REG_STATUS, 32'h0000_0000, 32'h0000_0001);
      set_trips(12'h300);
      wait_fire("l1 inj", (PL1 + PINJ - 2) * TL + 2, (PL1 + PINJ + 3) * TL + 10,
         12'hff0, 12'hff0);
      repeat (80) @(negedge clk);
      `CHK("eq without l05", 4'h0, fire.eq)
      set_trips(12'h330);
      wait_fire("eq", 0, 12, 12'h00f, 12'h00f);
      // abort attempt by the operator and dropped trips
      set_trips(12'h000);
      op(4'hf);
      rd_reg("sealed", REG_STATUS, 32'h0000_0019, 32'h0000_001f);
      `CHK("still fired", 12'hfff, fv)
      do_reset();
      rd_reg("status", REG_STATUS, 32'h0000_0000, 32'hffff_ffff);
      // failed scram inhibit, then drywell pressure initiation
      failed_scram_condition <= 1'b1;
      set_trips(12'h330);
      repeat (120) @(negedge clk);
      `CHK("inhibited", 12'h000, fv)
      rd_reg("no auto seal", REG_STATUS, 32'h0000_0000, 32'h0000_0001);
      do_reset();
      set_trips(12'h003);
      wait_fire("dwp inj", (PDW + PINJ - 2) * TL + 2, (PDW + PINJ + 3) * TL + 10,
         12'hff0, 12'hff0);
      // system manual initiation
      do_reset();
      op(4'h5);
      repeat (40) @(negedge clk);
      `CHK("manual high pressure", 12'h000, fv)
      do_reset();
      @(posedge clk);
      low_pressure <= 1'b1;
      op(4'h2);
      repeat (40) @(negedge clk);
      `CHK("one division", 12'h000, fv)
      op(4'h8);
      wait_fire("manual inj", 0, (PINJ + 3) * TL + 10, 12'hff0, 12'hff0);
      rd_reg("man seal", REG_STATUS, 32'h0000_0002, 32'h0000_0002);
      // per valve arm and fire
      do_reset();
      a = $urandom & 32'h0000_0fff;
      f = $urandom & 32'h0000_0fff;
      wr_reg(REG_VALVE_ARM, a);
      repeat (2) @(negedge clk);
      `CHK("valve arm alarm", 1'(a != 0), alarm_arm)
      wr_reg(REG_VALVE_FIRE, f);
      rd_reg("refused fire", REG_VALVE_OUT, 32'h0, 32'h0000_0fff);
      rd_reg("arm word", REG_VALVE_ARM, a, 32'h0000_0fff);
      rd_reg("fire word", REG_VALVE_FIRE, 32'h0, 32'hffff_ffff);
      @(posedge clk);
      low_pressure <= 1'b1;
      wr_reg(REG_VALVE_FIRE, f);
      rd_reg("valve fire", REG_VALVE_OUT, {20'h0, a[7:0] & f[7:0], a[11:8] & f[11:8]},
         32'h0000_0fff);
      `CHK("valve pins", {a[7:0] & f[7:0], a[11:8] & f[11:8]}, fv)
      // pool level alarms in every combination
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         pool_level_high <= 1'(i);
         pool_level_low <= 1'(i >> 1);
         repeat (3) @(negedge clk);
         `CHK("pool alarms", 2'(i), {alarm_pool_low, alarm_pool_high})
      end
      repeat (4) @(posedge clk);
      results();
   end
endmodule // cooling_injection_actuation_sequencer_bench
